// *** pkg/adcsm_cfg.svh ***
`ifndef ADCSM_CFG_SVH
`define ADCSM_CFG_SVH

// Register address codes carried in the command byte.
`define ADCSM_ADDR_STAT  3'h0
`define ADCSM_ADDR_MODE  3'h1
`define ADCSM_ADDR_DATA  3'h3

// Command byte field positions.
`define ADCSM_CMD_WEN    7
`define ADCSM_CMD_RD     6
`define ADCSM_CMD_ADDR_HI 5
`define ADCSM_CMD_ADDR_LO 3

// Reset values.
`define ADCSM_MODE_RST   24'h080060
`define ADCSM_STAT_RST   8'h80

// Mode register field positions.
`define ADCSM_MODE_OPM_HI 23
`define ADCSM_MODE_OPM_LO 21
`define ADCSM_MODE_DSTA  20
`define ADCSM_MODE_CLK_HI 19
`define ADCSM_MODE_CLK_LO 18
`define ADCSM_MODE_AVG_HI 17
`define ADCSM_MODE_AVG_LO 16
`define ADCSM_MODE_THIRD_ORDER_FILTER_SELECT 15
`define ADCSM_MODE_ZERO  14
`define ADCSM_MODE_PAR   13
`define ADCSM_MODE_HALVE 12
`define ADCSM_MODE_SINGLE 11
`define ADCSM_MODE_SIXTY_HZ_NOTCH_ENABLE 10
`define ADCSM_MODE_FS_HI 9
`define ADCSM_MODE_FS_LO 0
`define ADCSM_MODE_MASK  24'hffbfff

// Serial frame lengths in bits.
`define ADCSM_LEN_CMD    6'h08
`define ADCSM_LEN_STAT   6'h08
`define ADCSM_LEN_WORD   6'h18
`define ADCSM_LEN_DSTA   6'h20

`endif

// *** pkg/adcsm_pkg.sv ***
package adcsm_pkg;

    typedef enum logic [1:0] {
        ST_COMM,
        ST_WR,
        ST_RD
    } adcsm_state_t;

endpackage : adcsm_pkg

// *** rtl/adcsm_sync.sv ***
`timescale 1ns/100ps

// Two-flop synchroniser for the serial pins; idles high like the pins.
module adcsm_sync (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [2:0] i_async,
    output logic      [2:0] o_sync
);

    logic [2:0] meta_reg;
    logic [2:0] sync_reg;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_reg <= 3'h7;
            sync_reg <= 3'h7;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : adcsm_sync

// *** rtl/adcsm_regs.sv ***
`timescale 1ns/100ps
`include "adcsm_cfg.svh"

module adcsm_regs (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_din,
    output logic             o_dout,
    input  wire logic        i_conv_valid,
    input  wire logic [23:0] i_conv_data,
    input  wire logic [3:0]  i_conv_chan,
    input  wire logic        i_conv_err,
    input  wire logic        i_conv_over,
    input  wire logic        i_ref_low,
    input  wire logic        i_ref_det_en,
    output logic [23:0]      o_mode_ctrl,
    output logic             o_filt_reset,
    output logic             o_data_ready
);

    function automatic logic [5:0] xfer_len(input logic [2:0] addr,
                                            input logic       rd,
                                            input logic       dsta);
        if (rd && addr == `ADCSM_ADDR_STAT) begin
            xfer_len = `ADCSM_LEN_STAT;
        end else if (rd && addr == `ADCSM_ADDR_DATA && dsta) begin
            xfer_len = `ADCSM_LEN_DSTA;
        end else begin
            xfer_len = `ADCSM_LEN_WORD;
        end
    endfunction : xfer_len

    // Read words are left aligned so the shifter always sends bit 31 first.
    function automatic logic [31:0] read_word(input logic [2:0]  addr,
                                              input logic [7:0]  stat,
                                              input logic [23:0] mode,
                                              input logic [23:0] data);
        if (addr == `ADCSM_ADDR_STAT) begin
            read_word = {stat, 24'h000000};
        end else if (addr == `ADCSM_ADDR_MODE) begin
            read_word = {mode, 8'h00};
        end else if (addr == `ADCSM_ADDR_DATA) begin
            read_word = {data, stat};
        end else begin
            read_word = 32'h00000000;
        end
    endfunction : read_word

    logic [2:0]                sync_w;
    logic                      sclk_s;
    logic                      csn_s;
    logic                      din_s;
    logic                      sclk_d_reg;
    logic                      rise;
    logic                      fall;
    adcsm_pkg::adcsm_state_t   state_reg,  state_next;
    logic [5:0]                cnt_reg,    cnt_next;
    logic [5:0]                len_reg,    len_next;
    logic [2:0]                addr_reg,   addr_next;
    logic [23:0]               rx_reg,     rx_next;
    logic [31:0]               tx_reg,     tx_next;
    logic                      dout_reg,   dout_next;
    logic                      mode_wr;
    logic                      data_rd_done;
    logic [23:0]               wr_val;
    logic [23:0]               mode_reg,   mode_next;
    logic [23:0]               data_reg,   data_next;
    logic                      rdy_reg,    rdy_next;
    logic                      err_reg,    err_next;
    logic                      missing_reference_flag_reg,  missing_reference_flag_next;
    logic                      par_reg,    par_next;
    logic [3:0]                chan_reg,   chan_next;
    logic                      filt_reg,   filt_next;
    logic [7:0]                status;

    adcsm_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   ({i_sclk, i_cs_n, i_din}),
        .o_sync    (sync_w)
    );

    assign sclk_s = sync_w[2];
    assign csn_s  = sync_w[1];
    assign din_s  = sync_w[0];
    assign rise   = sclk_s & ~sclk_d_reg;
    assign fall   = ~sclk_s & sclk_d_reg;
    assign status = {rdy_reg, err_reg, missing_reference_flag_reg, par_reg, chan_reg};
    assign wr_val = {rx_reg[22:0], din_s} & `ADCSM_MODE_MASK;

    // Serial engine: sample on rising SCLK, shift out on falling SCLK.
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        len_next     = len_reg;
        addr_next    = addr_reg;
        rx_next      = rx_reg;
        tx_next      = tx_reg;
        dout_next    = dout_reg;
        mode_wr      = 1'b0;
        data_rd_done = 1'b0;
        if (csn_s) begin
            state_next = adcsm_pkg::ST_COMM;
            cnt_next   = 6'h00;
        end else if (rise) begin
            rx_next  = {rx_reg[22:0], din_s};
            cnt_next = cnt_reg + 6'h01;
            case (state_reg)
                adcsm_pkg::ST_COMM: begin
                    if (cnt_next == `ADCSM_LEN_CMD) begin
                        cnt_next  = 6'h00;
                        addr_next = rx_next[`ADCSM_CMD_ADDR_HI:
                                            `ADCSM_CMD_ADDR_LO];
                        // A command with the write-enable bit high is dropped.
                        if (!rx_next[`ADCSM_CMD_WEN]) begin
                            if (rx_next[`ADCSM_CMD_RD]) begin
                                state_next = adcsm_pkg::ST_RD;
                                len_next   = xfer_len(addr_next, 1'b1,
                                    mode_reg[`ADCSM_MODE_DSTA]);
                                tx_next    = read_word(addr_next, status,
                                    mode_reg, data_reg);
                            end else if (addr_next != `ADCSM_ADDR_STAT) begin
                                state_next = adcsm_pkg::ST_WR;
                                len_next   = xfer_len(addr_next, 1'b0, 1'b0);
                            end
                        end
                    end
                end
                adcsm_pkg::ST_WR: begin
                    if (cnt_next == len_reg) begin
                        state_next = adcsm_pkg::ST_COMM;
                        cnt_next   = 6'h00;
                        mode_wr    = (addr_reg == `ADCSM_ADDR_MODE);
                    end
                end
                adcsm_pkg::ST_RD: begin
                    if (cnt_next == len_reg) begin
                        state_next   = adcsm_pkg::ST_COMM;
                        cnt_next     = 6'h00;
                        data_rd_done = (addr_reg == `ADCSM_ADDR_DATA);
                    end
                end
                default: begin
                    state_next = adcsm_pkg::ST_COMM;
                end
            endcase
        end else if (fall && state_reg == adcsm_pkg::ST_RD) begin
            dout_next = tx_reg[31];
            tx_next   = {tx_reg[30:0], 1'b0};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sclk_d_reg <= 1'b1;
            state_reg  <= adcsm_pkg::ST_COMM;
            cnt_reg    <= 6'h00;
            len_reg    <= 6'h00;
            addr_reg   <= 3'h0;
            rx_reg     <= 24'h000000;
            tx_reg     <= 32'h00000000;
            dout_reg   <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            len_reg    <= len_next;
            addr_reg   <= addr_next;
            rx_reg     <= rx_next;
            tx_reg     <= tx_next;
            dout_reg   <= dout_next;
        end
    end

    // Register group. A mode write beats a finished conversion on the ready
    // flag, so a result that raced the write is never reported as fresh.
    always_comb begin
        logic       missing_reference_flag;
        logic [23:0] res;
        missing_reference_flag      = 1'b0;
        res        = i_conv_data;
        mode_next  = mode_reg;
        data_next  = data_reg;
        rdy_next   = rdy_reg;
        err_next   = err_reg;
        missing_reference_flag_next = missing_reference_flag_reg;
        par_next   = par_reg;
        chan_next  = chan_reg;
        filt_next  = mode_wr;
        if (i_conv_valid) begin
            missing_reference_flag = i_ref_det_en & i_ref_low;
            if (missing_reference_flag) begin
                res = 24'hffffff;
            end else if (i_conv_err) begin
                res = i_conv_over ? 24'hffffff : 24'h000000;
            end
            data_next  = res;
            err_next   = i_conv_err | missing_reference_flag;
            missing_reference_flag_next = missing_reference_flag;
            par_next   = mode_reg[`ADCSM_MODE_PAR] & (^res);
            chan_next  = i_conv_chan;
            rdy_next   = 1'b0;
        end else if (data_rd_done) begin
            rdy_next = 1'b1;
        end
        if (mode_wr) begin
            mode_next = wr_val;
            rdy_next  = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mode_reg  <= `ADCSM_MODE_RST;
            data_reg  <= 24'h000000;
            rdy_reg   <= |(`ADCSM_STAT_RST & 8'h80);
            err_reg   <= 1'b0;
            missing_reference_flag_reg <= 1'b0;
            par_reg   <= 1'b0;
            chan_reg  <= 4'h0;
            filt_reg  <= 1'b0;
        end else begin
            mode_reg  <= mode_next;
            data_reg  <= data_next;
            rdy_reg   <= rdy_next;
            err_reg   <= err_next;
            missing_reference_flag_reg <= missing_reference_flag_next;
            par_reg   <= par_next;
            chan_reg  <= chan_next;
            filt_reg  <= filt_next;
        end
    end

    assign o_mode_ctrl  = mode_reg;
    assign o_filt_reset = filt_reg;
    assign o_data_ready = ~rdy_reg;
    assign o_dout       = dout_reg;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    chk_mode_reset: assert property ($past(i_rst) |-> mode_reg == 24'h080060 && status == 8'h80)
        else $error("Mode or status not at reset value.");
    chk_mode_write: assert property (mode_wr |=> rdy_reg && o_filt_reset ##1 !o_filt_reset)
        else $error("Mode write did not reset filter or set ready.");
    chk_bit14_zero: assert property (mode_reg[14] == 1'b0)
        else $error("Mode bit 14 is not zero.");
    chk_parity_flag: assert property (i_conv_valid && mode_reg[13] |=> par_reg == ^data_reg)
        else $error("Parity flag wrong.");
    chk_error_clamp: assert property (i_conv_valid && (i_conv_err || missing_reference_flag_next) |=> data_reg == 24'h000000 || data_reg == 24'hffffff)
        else $error("Error result not clamped.");
    chk_missing_reference_flag_gate: assert property (i_conv_valid && !i_ref_det_en |=> !missing_reference_flag_reg)
        else $error("Missing reference flagged while detect disabled.");
    chk_append_len: assert property (state_reg == adcsm_pkg::ST_COMM && state_next == adcsm_pkg::ST_RD && addr_next == 3'h3 && mode_reg[20] |=> len_reg == 6'h20)
        else $error("Data read without appended status.");
    chk_msb_first: assert property (fall && !csn_s && state_reg == adcsm_pkg::ST_RD |=> o_dout == $past(tx_reg[31]))
        else $error("Serial output not most significant bit first.");
    chk_status_write: assert property (state_reg == adcsm_pkg::ST_COMM && state_next == adcsm_pkg::ST_COMM && cnt_reg == 6'h07 && rise |=> $stable(mode_reg))
        else $error("Command byte disturbed the mode register.");

    cov_mode_write: cover property (mode_wr);
    cov_data_read: cover property (data_rd_done && mode_reg[20]);
    cov_conv_error: cover property (i_conv_valid && i_conv_err);

endmodule : adcsm_regs

// *** sim/adcsm_host_model.sv ***
`timescale 1ns/100ps

// Host side of the serial link. The clock idles high and stands still
// between frames.
module adcsm_host_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_din,
    input  wire logic i_dout
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end

    // Each reply bit is taken late in the high phase, where it has settled.
    task automatic xfer(input int n, input logic [39:0] tx,
                        output logic [39:0] rx);
        rx     = '0;
        o_cs_n = 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_din  = tx[i];
            #80;
            o_sclk = 1'b1;
            #80;
            rx = {rx[38:0], i_dout};
        end
        o_cs_n = 1'b1;
        // A released data line must not look like the last bit held.
        o_din = ~o_din;
        #160;
    endtask : xfer
endmodule : adcsm_host_model

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`include "adcsm_cfg.svh"

module tb_top;
    logic        clk;
    logic        rst;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        cv;
    logic        cerr;
    logic        cover_hi;
    logic        rlow;
    logic        rdet;
    logic [23:0] cdata;
    logic [3:0]  cchan;
    logic [23:0] mode;
    logic        filt;
    logic        rdy;
    logic [39:0] rx;
    int          failures = 0;
    int          n_checks = 0;
    int          n_filt   = 0;

    adcsm_regs dut (.i_sys_clk(clk), .i_rst(rst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .i_conv_valid(cv),
        .i_conv_data(cdata), .i_conv_chan(cchan), .i_conv_err(cerr),
        .i_conv_over(cover_hi), .i_ref_low(rlow), .i_ref_det_en(rdet),
        .o_mode_ctrl(mode), .o_filt_reset(filt), .o_data_ready(rdy));

    adcsm_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
        .i_dout(dout));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (filt === 1'b1) n_filt <= n_filt + 1;

    task automatic check(input string what, input logic [39:0] exp,
                         input logic [39:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic wr_mode(input logic [23:0] v);
        host.xfer(32, {8'h00, 8'h08, v}, rx);
    endtask : wr_mode

    task automatic conv(input logic [23:0] d, input logic [3:0] ch,
                        input logic e, input logic o, input logic rl);
        @(negedge clk);
        cv       = 1'b1;
        cdata    = d;
        cchan    = ch;
        cerr     = e;
        cover_hi = o;
        rlow     = rl;
        @(negedge clk);
        cv = 1'b0;
        repeat (2) @(negedge clk);
    endtask : conv

    task automatic t_reset;
        host.xfer(16, 40'h4000, rx);
        check("status", `ADCSM_STAT_RST, rx[7:0]);
        host.xfer(32, 40'h48000000, rx);
        check("mode", `ADCSM_MODE_RST, rx[23:0]);
        check("mode port", `ADCSM_MODE_RST, mode);
        check("ready", 1'b0, rdy);
        host.xfer(32, 40'h60000000, rx);
        check("unmapped", 24'h0, rx[23:0]);
    endtask : t_reset

    task automatic t_mode_write;
        int f;
        f = n_filt;
        wr_mode(24'hffffff);
        check("filter reset", f + 1, n_filt);
        check("mode port", 24'hffbfff, mode);
        host.xfer(32, 40'h48000000, rx);
        check("mode bit 14", 24'hffbfff, rx[23:0]);
        host.xfer(8, 40'h00, rx);
        host.xfer(16, 40'h4000, rx);
        check("status kept", 8'h80, rx[7:0]);
        // Append and parity on together, as a careful host does.
        wr_mode(24'h102060);
        host.xfer(32, 40'h48000000, rx);
        check("mode fields", 24'h102060, rx[23:0]);
    endtask : t_mode_write

    task automatic t_parity;
        conv(24'h000007, 4'h5, 1'b0, 1'b0, 1'b0);
        check("ready", 1'b1, rdy);
        host.xfer(16, 40'h4000, rx);
        check("status odd", 8'h15, rx[7:0]);
        host.xfer(40, 40'h5800000000, rx);
        check("data append", 32'h00000715, rx[31:0]);
        check("ready read", 1'b0, rdy);
        conv(24'h000003, 4'h2, 1'b0, 1'b0, 1'b0);
        host.xfer(40, 40'h5800000000, rx);
        check("data even", 32'h00000302, rx[31:0]);
    endtask : t_parity

    task automatic t_ready_on_write;
        int f;
        conv(24'h000001, 4'h1, 1'b0, 1'b0, 1'b0);
        check("ready", 1'b1, rdy);
        f = n_filt;
        wr_mode(24'h102060);
        check("ready cleared", 1'b0, rdy);
        check("filter reset", f + 1, n_filt);
    endtask : t_ready_on_write

    // A write to another register and a command with the write-enable bit
    // high must both leave the mode register and the filter alone.
    task automatic t_refused;
        int f;
        f = n_filt;
        host.xfer(32, 40'h10ffffff, rx);
        host.xfer(8, 40'h88, rx);
        host.xfer(32, 40'h48000000, rx);
        check("mode kept", 24'h102060, rx[23:0]);
        check("no filter reset", f, n_filt);
    endtask : t_refused

    task automatic t_clamp;
        conv(24'h123456, 4'h1, 1'b1, 1'b1, 1'b0);
        host.xfer(40, 40'h5800000000, rx);
        check("clamp ones", 32'hffffff41, rx[31:0]);
        conv(24'h123456, 4'h1, 1'b1, 1'b0, 1'b0);
        host.xfer(40, 40'h5800000000, rx);
        check("clamp zeros", 32'h00000041, rx[31:0]);
    endtask : t_clamp

    task automatic t_missing_reference_flag;
        @(negedge clk);
        rdet = 1'b0;
        conv(24'h000001, 4'h3, 1'b0, 1'b0, 1'b1);
        host.xfer(40, 40'h5800000000, rx);
        check("no detect", 32'h00000113, rx[31:0]);
        @(negedge clk);
        rdet = 1'b1;
        conv(24'h000001, 4'h3, 1'b0, 1'b0, 1'b1);
        host.xfer(40, 40'h5800000000, rx);
        check("missing_reference_flag data", 24'hffffff, rx[31:8]);
        check("missing_reference_flag flag", 1'b1, rx[5]);
    endtask : t_missing_reference_flag

    // Reset in mid-run, with a written mode and flags raised, must bring
    // every register back to its power-on value.
    task automatic t_reset_again;
        @(negedge clk);
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("mode port", `ADCSM_MODE_RST, mode);
        check("ready", 1'b0, rdy);
        host.xfer(16, 40'h4000, rx);
        check("status", `ADCSM_STAT_RST, rx[7:0]);
    endtask : t_reset_again

    initial begin
        rst      = 1'b1;
        cv       = 1'b0;
        cerr     = 1'b0;
        cover_hi = 1'b0;
        rlow     = 1'b0;
        rdet     = 1'b0;
        cdata    = 24'h000000;
        cchan    = 4'h0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_mode_write();
        t_parity();
        t_ready_on_write();
        t_refused();
        t_clamp();
        t_missing_reference_flag();
        t_reset_again();
        final_report();
    end

    // The sequence needs about 5200 cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : tb_top
